/* logic/clock_startup_regs.svh */
// Register offsets, field positions, reset values and start-up counts
// Assumes a 32-bit AHB-Lite word-addressed register map
`ifndef CLOCK_STARTUP_REGS_SVH
`define CLOCK_STARTUP_REGS_SVH

`define FUSE_ADDR 8'h00
`define CTRL_ADDR 8'h04
`define STAT_ADDR 8'h08

`define FUSE_SEL_LSB 0
`define FUSE_SUT_LSB 4
`define FUSE_DIV_BIT 6
`define FUSE_WIDTH 7
// Shipped default: source 0010, start-up 10, divide-by-8 programmed
`define FUSE_RESET 7'h22

`define CTRL_MODE_LSB 0
`define STAT_SEQ_LSB 0
`define STAT_RST_BIT 2
`define STAT_SRC_LSB 3
`define STAT_RANGE_LSB 6
`define STAT_MODE_LSB 9

`define CK_258 16'h0102
`define CK_1K 16'h0400
`define CK_16K 16'h4000
`define CK_32K 16'h8000
`define CK_RC_EXT 16'h0006
`define CK_RESET_EXTRA 16'h000E
`define TOUT_SHORT_CK 14'h0200
`define TOUT_LONG_CK 14'h2000

`endif

/* logic/clock_startup_pkg.sv */
// Types shared by the clock start-up control block
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package clock_startup_pkg;
  typedef enum logic [2:0] {
    SRC_LP_XTAL = 3'b000,
    SRC_FS_XTAL = 3'b001,
    SRC_LF_XTAL = 3'b010,
    SRC_RC128 = 3'b011,
    SRC_RC_CAL = 3'b100,
    SRC_EXT = 3'b101,
    SRC_RSVD = 3'b110
  } source_t;
  typedef enum logic [1:0] {
    TOUT_NONE = 2'b00,
    TOUT_SHORT = 2'b01,
    TOUT_LONG = 2'b10
  } tout_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TIMEOUT = 2'b01,
    SEQ_STARTUP = 2'b10,
    SEQ_RUN = 2'b11
  } seq_state_t;
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_ADC_QUIET = 2'b10,
    MODE_PWR_DOWN = 2'b11
  } sleep_mode_t;
  typedef struct packed {
    logic [15:0] ck;
    tout_t tout;
  } plan_t;
endpackage
`default_nettype wire

/* logic/startup_if.sv */
// Signals between the control top, the start-up sequencer and the divider
// Assumes all parties run on mclk_i
`default_nettype none
interface startup_if;
  logic start;
  logic from_reset;
  logic [13:0] timeout_len;
  logic [15:0] startup_len;
  logic wdt_tick;
  logic src_tick;
  logic div_on;
  logic sys_tick;
  logic hold_reset;
  clock_startup_pkg::seq_state_t seq_state;
  modport ctl(output start, from_reset, timeout_len, startup_len, wdt_tick, src_tick,
    div_on, input sys_tick, hold_reset, seq_state);
  modport seq(input start, from_reset, timeout_len, startup_len, wdt_tick, src_tick,
    output hold_reset, seq_state);
  modport div(input src_tick, div_on, output sys_tick);
endinterface
`default_nettype wire

/* logic/startup_sequencer.sv */
// Time-out count on watchdog ticks, then oscillator start-up count
// Assumes tick inputs are one-cycle enables on mclk_i
`default_nettype none
module startup_sequencer (
  input wire logic mclk_i,
  input wire logic resetn_i,
  startup_if.seq sq
);
  typedef struct packed {
    clock_startup_pkg::seq_state_t st;
    logic cold;
    logic [15:0] cnt;
  } seq_reg_t;
  seq_reg_t r;
  seq_reg_t next_r;

  always_comb begin
    next_r = r;
    if (sq.start) begin
      next_r.cold = sq.from_reset;
      if (sq.from_reset && sq.timeout_len != 14'h0000) begin
        next_r.st = clock_startup_pkg::SEQ_TIMEOUT; // [RQ4] [RQ7]
        next_r.cnt = {2'h0, sq.timeout_len};
      end else begin
        next_r.st = clock_startup_pkg::SEQ_STARTUP; // [RQ7]
        next_r.cnt = sq.startup_len;
      end
    end else begin
      case (r.st)
        clock_startup_pkg::SEQ_TIMEOUT: begin
          if (r.cnt == 16'h0000) begin
            next_r.st = clock_startup_pkg::SEQ_STARTUP; // [RQ19]
            next_r.cnt = sq.startup_len;
          end else if (sq.wdt_tick) begin
            next_r.cnt = r.cnt - 16'h0001; // [RQ4]
          end
        end
        clock_startup_pkg::SEQ_STARTUP: begin
          if (r.cnt == 16'h0000) begin
            next_r.st = clock_startup_pkg::SEQ_RUN; // [RQ6] [RQ19]
          end else if (sq.src_tick) begin
            next_r.cnt = r.cnt - 16'h0001; // [RQ6]
          end
        end
        clock_startup_pkg::SEQ_IDLE: begin
          next_r.st = clock_startup_pkg::SEQ_IDLE;
        end
        clock_startup_pkg::SEQ_RUN: begin
          next_r.st = clock_startup_pkg::SEQ_RUN;
        end
        default: begin
          next_r.st = clock_startup_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '{st: clock_startup_pkg::SEQ_IDLE, cold: 1'b1, cnt: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  // A wake restart never asserts reset; only a cold start holds it
  assign sq.hold_reset = r.cold && (r.st != clock_startup_pkg::SEQ_RUN); // [RQ19]
  assign sq.seq_state = r.st;
endmodule // startup_sequencer
`default_nettype wire

/* logic/sysclk_divider.sv */
// Optional divide-by-8 of the selected source tick
// Assumes src_tick is a one-cycle enable on mclk_i
`default_nettype none
module sysclk_divider (
  input wire logic mclk_i,
  input wire logic resetn_i,
  startup_if.div dv
);
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } div_reg_t;
  div_reg_t r;
  div_reg_t next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (dv.src_tick) begin
      if (!dv.div_on) begin
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 3'h1; // [RQ11]
        next_r.tick = (r.cnt == 3'h7);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '{cnt: 3'h0, tick: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign dv.sys_tick = r.tick;
endmodule // sysclk_divider
`default_nettype wire

/* logic/clock_startup_top.sv */
// Clock source selection, start-up sequencing and domain enables
// Assumes one 50 MHz clock; oscillators arrive as one-cycle tick enables
`include "clock_startup_regs.svh"
`default_nettype none

// Functional notes
// RQ1: Decode source-select fuses into oscillator source
// RQ2: Fuse one means unprogrammed, zero programmed
// RQ3: Default fuses: RC source, 10, divide on
// RQ4: Hold reset for watchdog-timed time-out
// RQ5: Time-out is 0, 512 or 8192 cycles
// RQ6: Ripple count holds reset, then releases
// RQ7: Cold start both counts; wake start-up only
// RQ8: Low power crystal range from bits 3:1
// RQ9: Low power start-up table, low bit clear
// RQ10: Low power start-up table, low bit set
// RQ11: Programmed divide fuse divides by eight
// RQ12: Gated core clock stops core operations
// RQ13: Some interrupts detected without peripheral clock
// RQ14: Serial start, address match wake anytime
// RQ15: Memory clock follows core clock
// RQ16: Async timer clock independent of system
// RQ17: Converter clock runs while core gated
// RQ18: Time-out disable only with brown-out guard
// RQ19: Start-up count follows time-out, then release
module clock_startup_top #(
  parameter logic [13:0] TIMEOUT_SHORT = `TOUT_SHORT_CK,
  parameter logic [13:0] TIMEOUT_LONG = `TOUT_LONG_CK
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic wdt_tick_i,
  input wire logic [5:0] src_tick_i,
  input wire logic asy_tick_i,
  input wire logic async_irq_i,
  input wire logic io_irq_i,
  input wire logic usi_start_i,
  input wire logic twi_addr_match_i,
  output logic core_clock_domain_o,
  output logic program_memory_clock_domain_o,
  output logic peripheral_clock_domain_o,
  output logic async_timer_clock_domain_o,
  output logic converter_clock_domain_o,
  output logic internal_reset_o,
  output logic wake_o
);
  generate
    if (TIMEOUT_SHORT == 14'h0000 || TIMEOUT_LONG < TIMEOUT_SHORT) begin : g_bad_timeout
      $error("clock_startup_top: time-out lengths out of range");
    end
  endgenerate

  typedef struct packed {
    logic [`FUSE_WIDTH-1:0] fuse;
    logic [`FUSE_WIDTH-1:0] act_fuse;
    clock_startup_pkg::sleep_mode_t mode;
    logic started;
    logic cold;
    logic start;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic core_en;
    logic flash_en;
    logic io_en;
    logic asy_en;
    logic adc_en;
    logic int_rst;
    logic wake;
  } top_reg_t;
  top_reg_t r;
  top_reg_t next_r;

  startup_if sif();

  startup_sequencer u_seq (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sq(sif.seq)
  );

  sysclk_divider u_div (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .dv(sif.div)
  );

  function automatic clock_startup_pkg::source_t decode_source(input logic [3:0] sel);
    clock_startup_pkg::source_t s;
    s = clock_startup_pkg::SRC_RSVD;
    if (sel[3]) begin
      s = clock_startup_pkg::SRC_LP_XTAL; // [RQ1]
    end else begin
      case (sel[2:0])
        3'h7, 3'h6: s = clock_startup_pkg::SRC_FS_XTAL; // [RQ1]
        3'h5, 3'h4: s = clock_startup_pkg::SRC_LF_XTAL; // [RQ1]
        3'h3: s = clock_startup_pkg::SRC_RC128; // [RQ1]
        3'h2: s = clock_startup_pkg::SRC_RC_CAL; // [RQ1]
        3'h0: s = clock_startup_pkg::SRC_EXT; // [RQ1]
        default: s = clock_startup_pkg::SRC_RSVD; // [RQ1]
      endcase
    end
    return s;
  endfunction

  function automatic clock_startup_pkg::plan_t startup_plan(
      input clock_startup_pkg::source_t s, input logic low_bit, input logic [1:0] sut);
    clock_startup_pkg::plan_t p;
    p.ck = `CK_RC_EXT;
    p.tout = clock_startup_pkg::TOUT_LONG;
    case (s)
      clock_startup_pkg::SRC_LP_XTAL, clock_startup_pkg::SRC_FS_XTAL: begin
        case ({low_bit, sut})
          3'b000: p = '{`CK_258, clock_startup_pkg::TOUT_SHORT}; // [RQ9]
          3'b001: p = '{`CK_258, clock_startup_pkg::TOUT_LONG}; // [RQ9]
          3'b010: p = '{`CK_1K, clock_startup_pkg::TOUT_NONE}; // [RQ9]
          3'b011: p = '{`CK_1K, clock_startup_pkg::TOUT_SHORT}; // [RQ9]
          3'b100: p = '{`CK_1K, clock_startup_pkg::TOUT_LONG}; // [RQ10]
          3'b101: p = '{`CK_16K, clock_startup_pkg::TOUT_NONE}; // [RQ10]
          3'b110: p = '{`CK_16K, clock_startup_pkg::TOUT_SHORT}; // [RQ10]
          default: p = '{`CK_16K, clock_startup_pkg::TOUT_LONG}; // [RQ10]
        endcase
      end
      clock_startup_pkg::SRC_LF_XTAL: begin
        p.ck = low_bit ? `CK_32K : `CK_1K;
        // Reserved 11 falls back to the longest time-out, the safe side
        case (sut)
          2'b00: p.tout = clock_startup_pkg::TOUT_NONE;
          2'b01: p.tout = clock_startup_pkg::TOUT_SHORT;
          default: p.tout = clock_startup_pkg::TOUT_LONG;
        endcase
      end
      default: begin
        case (sut)
          2'b00: p.tout = clock_startup_pkg::TOUT_NONE;
          2'b01: p.tout = clock_startup_pkg::TOUT_SHORT;
          default: p.tout = clock_startup_pkg::TOUT_LONG;
        endcase
      end
    endcase
    return p;
  endfunction

  clock_startup_pkg::source_t src;
  clock_startup_pkg::plan_t plan;
  logic sel_tick;
  logic running;
  logic addr_phase;

  always_comb begin
    src = decode_source(r.act_fuse[`FUSE_SEL_LSB +: 4]);
    plan = startup_plan(src, r.act_fuse[`FUSE_SEL_LSB], r.act_fuse[`FUSE_SUT_LSB +: 2]);
    // Reserved source has no oscillator, so a cold start never completes
    sel_tick = (src == clock_startup_pkg::SRC_RSVD) ? 1'b0 : src_tick_i[src];
    running = (sif.seq_state == clock_startup_pkg::SEQ_RUN);
    addr_phase = hsel_i && htrans_i[1] && hready_i;
  end

  assign sif.start = r.start;
  assign sif.from_reset = r.cold;
  assign sif.wdt_tick = wdt_tick_i;
  assign sif.src_tick = sel_tick;
  assign sif.div_on = !r.act_fuse[`FUSE_DIV_BIT]; // [RQ2] [RQ11]
  assign sif.startup_len = r.cold ? plan.ck + `CK_RESET_EXTRA : plan.ck; // [RQ7] [RQ9]
  // Zero time-out is meant only for a supply guarded by a brown-out detector
  assign sif.timeout_len = (plan.tout == clock_startup_pkg::TOUT_NONE) ? 14'h0000 :
    (plan.tout == clock_startup_pkg::TOUT_SHORT) ? TIMEOUT_SHORT : TIMEOUT_LONG; // [RQ5] [RQ18]

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.wake = 1'b0;
    if (!r.started) begin
      next_r.started = 1'b1;
      next_r.start = 1'b1; // [RQ4] [RQ7]
      next_r.cold = 1'b1;
      next_r.act_fuse = r.fuse;
    end
    // Writes land in the data phase; FUSE and CTRL reads see them at once
    if (r.wr_pend) begin
      case (r.addr)
        `FUSE_ADDR: next_r.fuse = hwdata_i[`FUSE_WIDTH-1:0]; // [RQ2]
        `CTRL_ADDR: begin
          if (running && !r.cold && r.mode == clock_startup_pkg::MODE_ACTIVE) begin
            next_r.mode = clock_startup_pkg::sleep_mode_t'(hwdata_i[`CTRL_MODE_LSB +: 2]);
          end else if (running) begin
            next_r.mode = clock_startup_pkg::sleep_mode_t'(hwdata_i[`CTRL_MODE_LSB +: 2]);
          end
        end
        default: next_r.mode = r.mode;
      endcase
    end
    // Wake sources other than io_irq_i are watched whether or not the peripheral clock runs
    if (r.mode != clock_startup_pkg::MODE_ACTIVE && running &&
        (async_irq_i || usi_start_i || twi_addr_match_i ||
         (io_irq_i && r.mode == clock_startup_pkg::MODE_IDLE))) begin // [RQ13] [RQ14]
      next_r.wake = 1'b1;
      next_r.mode = clock_startup_pkg::MODE_ACTIVE;
      if (r.mode == clock_startup_pkg::MODE_PWR_DOWN) begin
        next_r.start = 1'b1; // [RQ7]
        next_r.cold = 1'b0;
        next_r.act_fuse = r.fuse;
      end
    end
    next_r.wr_pend = addr_phase && hwrite_i;
    if (addr_phase) begin
      next_r.addr = {haddr_i[7:2], 2'b00};
    end
    next_r.hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite_i) begin
      case ({haddr_i[7:2], 2'b00})
        `FUSE_ADDR: next_r.hrdata[`FUSE_WIDTH-1:0] = next_r.fuse;
        `CTRL_ADDR: next_r.hrdata[`CTRL_MODE_LSB +: 2] = next_r.mode;
        `STAT_ADDR: begin
          next_r.hrdata[`STAT_SEQ_LSB +: 2] = sif.seq_state;
          next_r.hrdata[`STAT_RST_BIT] = sif.hold_reset;
          next_r.hrdata[`STAT_SRC_LSB +: 3] = src;
          if (src == clock_startup_pkg::SRC_LP_XTAL) begin
            next_r.hrdata[`STAT_RANGE_LSB +: 3] = r.act_fuse[`FUSE_SEL_LSB + 1 +: 3]; // [RQ8]
          end
          next_r.hrdata[`STAT_MODE_LSB +: 2] = r.mode;
        end
        default: next_r.hrdata = 32'h0000_0000;
      endcase
    end
    // Domain enables other than the async timer one are one-cycle pulses at the system clock rate
    next_r.core_en = sif.sys_tick && running &&
      r.mode == clock_startup_pkg::MODE_ACTIVE; // [RQ12]
    next_r.flash_en = sif.sys_tick && running &&
      r.mode == clock_startup_pkg::MODE_ACTIVE; // [RQ15]
    next_r.io_en = sif.sys_tick && running &&
      (r.mode == clock_startup_pkg::MODE_ACTIVE ||
       r.mode == clock_startup_pkg::MODE_IDLE); // [RQ13]
    next_r.adc_en = sif.sys_tick && running &&
      r.mode != clock_startup_pkg::MODE_PWR_DOWN; // [RQ17]
    next_r.asy_en = asy_tick_i; // [RQ16]
    next_r.int_rst = sif.hold_reset; // [RQ6]
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '{fuse: `FUSE_RESET, act_fuse: `FUSE_RESET, // [RQ3]
        mode: clock_startup_pkg::MODE_ACTIVE, started: 1'b0, cold: 1'b1, start: 1'b0,
        wr_pend: 1'b0, addr: 8'h00, hrdata: 32'h0000_0000, core_en: 1'b0, flash_en: 1'b0,
        io_en: 1'b0, asy_en: 1'b0, adc_en: 1'b0, int_rst: 1'b1, wake: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Zero-wait slave: hreadyout and hresp are constant flops, never a stall
  logic ready_q;
  logic resp_q;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign hrdata_o = r.hrdata;
  assign hreadyout_o = ready_q;
  assign hresp_o = resp_q;
  assign core_clock_domain_o = r.core_en;
  assign program_memory_clock_domain_o = r.flash_en;
  assign peripheral_clock_domain_o = r.io_en;
  assign async_timer_clock_domain_o = r.asy_en;
  assign converter_clock_domain_o = r.adc_en;
  assign internal_reset_o = r.int_rst;
  assign wake_o = r.wake;
endmodule // clock_startup_top
`default_nettype wire

/* tb/clock_startup_props.sv */
// Port-level checks for the clock start-up control top
// Assumes one clock domain, bound onto every instance of the top
`default_nettype none
module clock_startup_props #(
  parameter logic [13:0] TIMEOUT_SHORT = 14'h0200,
  parameter logic [13:0] TIMEOUT_LONG = 14'h2000
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic wdt_tick_i,
  input wire logic [5:0] src_tick_i,
  input wire logic asy_tick_i,
  input wire logic async_irq_i,
  input wire logic io_irq_i,
  input wire logic usi_start_i,
  input wire logic twi_addr_match_i,
  input wire logic core_clock_domain_o,
  input wire logic program_memory_clock_domain_o,
  input wire logic peripheral_clock_domain_o,
  input wire logic async_timer_clock_domain_o,
  input wire logic converter_clock_domain_o,
  input wire logic internal_reset_o,
  input wire logic wake_o
);
  logic [15:0] since_rst;
  // Saturates so a long run never wraps into a false short hold
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_rst <= 16'h0000;
    end else if (since_rst != 16'hFFFF) begin
      since_rst <= since_rst + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  rst_gate_a: assert property (internal_reset_o |-> !core_clock_domain_o &&
    !peripheral_clock_domain_o && !converter_clock_domain_o) else $error("domain on in reset");
  flash_follow_a: assert property (program_memory_clock_domain_o == core_clock_domain_o)
    else $error("flash clock apart from core clock");
  // The first edge after release still shows the flop's reset value, so it is skipped
  async_copy_a: assert property ($past(resetn_i) |->
    async_timer_clock_domain_o == $past(asy_tick_i))
    else $error("timer clock not a copy of its tick");
  no_reassert_a: assert property (!$rose(internal_reset_o))
    else $error("internal reset raised without reset");
  hold_min_a: assert property ($fell(internal_reset_o) |->
    since_rst >= {2'h0, TIMEOUT_LONG} + 16'h0010) else $error("reset released too early");
  wake_cause_a: assert property (wake_o |->
    $past(async_irq_i || io_irq_i || usi_start_i || twi_addr_match_i))
    else $error("wake without a wake input");
  bus_ready_a: assert property (hreadyout_o) else $error("slave inserted a wait");
  bus_okay_a: assert property (!hresp_o) else $error("slave answered with error");
  cover property ($fell(internal_reset_o));
  cover property (wake_o);
  cover property (converter_clock_domain_o && !core_clock_domain_o);
endmodule // clock_startup_props
bind clock_startup_top clock_startup_props #(.TIMEOUT_SHORT(TIMEOUT_SHORT),
  .TIMEOUT_LONG(TIMEOUT_LONG)) i_clock_startup_props (.*);
`default_nettype wire

/* tb/osc_model.sv */
// Oscillator sources as one-cycle tick pulses on the system clock
// Assumes the bench calls pulse from one process at a time
`default_nettype none
module osc_model (
  input wire logic mclk_i,
  output logic wdt_tick_o,
  output logic [5:0] src_tick_o,
  output logic asy_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] asy_cnt;
  initial begin
    wdt_tick_o = 1'b0;
    src_tick_o = 6'h00;
    asy_tick_o = 1'b0;
    asy_cnt = 3'h0;
  end
  // Timer crystal runs on regardless of the selected source or sleep
  always @(posedge mclk_i) begin
    asy_cnt <= asy_cnt + 3'h1;
    asy_tick_o <= (asy_cnt == 3'h4);
  end
  // Index 6 is the watchdog oscillator; a gap cycle follows each tick
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      if (idx == 6) wdt_tick_o <= 1'b1;
      else src_tick_o[idx] <= 1'b1;
      @(posedge mclk_i);
      wdt_tick_o <= 1'b0;
      src_tick_o <= 6'h00;
    end
  endtask
endmodule // osc_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the clock start-up control top
// Assumes the checker binds itself; time-outs shortened to 4 and 16 ticks
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [3:0] wk = 4'h0;
  wire logic hready_i;
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o;
  wire logic hresp_o;
  wire logic wdt_tick_i;
  wire logic [5:0] src_tick_i;
  wire logic asy_tick_i;
  wire logic async_irq_i = wk[0];
  wire logic io_irq_i = wk[1];
  wire logic usi_start_i = wk[2];
  wire logic twi_addr_match_i = wk[3];
  wire logic core_clock_domain_o;
  wire logic program_memory_clock_domain_o;
  wire logic peripheral_clock_domain_o;
  wire logic async_timer_clock_domain_o;
  wire logic converter_clock_domain_o;
  wire logic internal_reset_o;
  wire logic wake_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int cnt [5];
  logic [31:0] r;
  logic v;
  assign hready_i = hreadyout_o;
  clock_startup_top #(.TIMEOUT_SHORT(14'h0004), .TIMEOUT_LONG(14'h0010))
    i_clock_startup_top (.*);
  osc_model i_osc_model (.mclk_i(mclk_i), .wdt_tick_o(wdt_tick_i),
    .src_tick_o(src_tick_i), .asy_tick_o(asy_tick_i));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // Sampled mid-cycle so registered pulses are counted without a race
  always @(negedge mclk_i) begin
    if (core_clock_domain_o === 1'b1) cnt[0]++;
    if (program_memory_clock_domain_o === 1'b1) cnt[1]++;
    if (peripheral_clock_domain_o === 1'b1) cnt[2]++;
    if (converter_clock_domain_o === 1'b1) cnt[3]++;
    if (wake_o === 1'b1) cnt[4]++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic ok;
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do begin
      @(negedge mclk_i);
      ok = hreadyout_o;
      @(posedge mclk_i);
    end while (ok !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do begin
      @(negedge mclk_i);
      ok = hreadyout_o;
      r = hrdata_o;
      @(posedge mclk_i);
    end while (ok !== 1'b1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic rst_now;
    @(negedge mclk_i);
    v = internal_reset_o;
    @(posedge mclk_i);
  endtask
  task automatic wake_in(input int k);
    wk[k] <= 1'b1;
    @(posedge mclk_i);
    wk[k] <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic t_reset;
    rst_now();
    chk(v, 1'b1);
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h22);
    ahb(1'b1, 32'h4, 32'h2);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[5:0], 6'h25);
    ahb(1'b0, 32'h4, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    chk(r, 32'h0);
  endtask
  // Source ticks before the time-out ends must not count
  task automatic t_cold;
    i_osc_model.pulse(4, 30);
    i_osc_model.pulse(6, 15);
    rst_now();
    chk(v, 1'b1);
    i_osc_model.pulse(6, 1);
    i_osc_model.pulse(4, 19);
    rst_now();
    chk(v, 1'b1);
    i_osc_model.pulse(4, 1);
    for (int i = 0; i < 8 && v !== 1'b0; i++) rst_now();
    chk(v, 1'b0);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[2:0], 3'h3);
  endtask
  task automatic t_domains(input int m);
    ahb(1'b1, 32'h4, m);
    cnt = '{default: 0};
    i_osc_model.pulse(4, 32);
    cyc(4);
    chk(cnt[0], (m == 0) ? 4 : 0);
    chk(cnt[1], (m == 0) ? 4 : 0);
    chk(cnt[2], (m < 2) ? 4 : 0);
    chk(cnt[3], 4);
    ahb(1'b1, 32'h4, 32'h0);
  endtask
  // Peripheral interrupt only leaves idle; the others are tried here from ADC quiet mode only
  task automatic t_wakes;
    int w0;
    ahb(1'b1, 32'h4, 32'h2);
    wake_in(1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(r[1:0], 2'h2);
    for (int k = 0; k < 4; k++) begin
      ahb(1'b1, 32'h4, (k == 1) ? 32'h1 : 32'h2);
      w0 = cnt[4];
      wake_in(k);
      cyc(2);
      chk(cnt[4] - w0, 1);
      ahb(1'b0, 32'h4, 32'h0);
      chk(r, 32'h0);
    end
  endtask
  task automatic t_powerdown;
    ahb(1'b1, 32'h0, 32'h4E);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[8:3], 6'h04);
    ahb(1'b1, 32'h4, 32'h3);
    cnt = '{default: 0};
    wake_in(3);
    i_osc_model.pulse(0, 257);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[8:0], 9'h1C2);
    i_osc_model.pulse(0, 1);
    cyc(6);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[2:0], 3'h3);
    chk(cnt[0] + cnt[2], 0);
    i_osc_model.pulse(0, 8);
    cyc(4);
    chk(cnt[0], 8);
    ahb(1'b1, 32'h0, 32'h4F);
    ahb(1'b1, 32'h4, 32'h3);
    wake_in(0);
    i_osc_model.pulse(0, 1023);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[2:0], 3'h2);
    i_osc_model.pulse(0, 1);
    cyc(4);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r[2:0], 3'h3);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    resetn_i <= 1'b1;
    cyc(2);
    t_reset();
    t_cold();
    t_domains(0);
    t_domains(1);
    t_domains(2);
    t_wakes();
    t_powerdown();
    resetn_i <= 1'b0;
    cyc(3);
    resetn_i <= 1'b1;
    cyc(2);
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h22);
    conclude();
  end
  // Whole run needs about 3000 cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    conclude();
  end
endmodule // testbench
`default_nettype wire
